// ### include/mtrl_pkg.sv
package mtrl_pkg;
   // architectural address width and block sizes
   localparam int ARCH_PA_W   = 52;
   localparam int PAGE_SHIFT  = 12;
   localparam int NUM_VAR     = 8;
   localparam int NUM_FIX     = 11;
   localparam int FIELD_W     = 8;
   localparam int REG_W       = 64;
   // register selector values on the model register port
   localparam logic [4:0] SEL_FIX64K_00 = 5'h00;
   localparam logic [4:0] SEL_FIX16K_80 = 5'h01;
   localparam logic [4:0] SEL_FIX16K_A0 = 5'h02;
   localparam logic [4:0] SEL_FIX4K_C0  = 5'h03;  // c0..f8 occupy 03..0a in order
   localparam logic [4:0] SEL_VAR_BASE0 = 5'h0b;  // base n at 0b+2n, mask n at 0c+2n
   localparam logic [4:0] SEL_DEF_TYPE  = 5'h1b;
   // field positions
   localparam int TYPE_LSB    = 0;
   localparam int TYPE_MSB    = 7;
   localparam int VALID_BIT   = 11;
   localparam int FE_BIT      = 10;
   localparam int EN_BIT      = 11;
   localparam int EXT_RD_BIT  = 4;
   localparam int EXT_WR_BIT  = 3;
   // reset values (not documented; cleared to disabled)
   localparam logic [63:0] RST_VALUE = 64'h0;
   // address region boundaries in the lowest megabyte, as 4k page numbers
   localparam logic [7:0] PG_16K_START = 8'h80;
   localparam logic [7:0] PG_4K_START  = 8'hc0;
   // memory type codes
   typedef enum logic [2:0] {
      MT_UNCACHEABLE    = 3'h0,
      MT_WRITE_COMBINE  = 3'h1,
      MT_WRITE_THROUGH  = 3'h4,
      MT_WRITE_PROTECT  = 3'h5,
      MT_WRITE_BACK     = 3'h6
   } mtrl_type_t;
endpackage : mtrl_pkg

// ### tb/mtrl_access_model.sv
`timescale 1ns/1ns
`default_nettype none
// memory access path issuing lookup requests
module mtrl_access_model #(
   parameter int PA_W = 52
) (
   output logic            req_out,   // request strobe
   output logic [PA_W-1:0] addr_out   // physical address
);
   // idle at time zero
   initial
   begin
      req_out = 1'b0;
      addr_out = '0;
   end
   // one request per call; released lines show the inverse of their last value
   task automatic drive(input logic req, input logic [PA_W-1:0] addr);
      req_out = req;
      addr_out = req ? addr : ~addr_out;
   endtask : drive
endmodule : mtrl_access_model
`default_nettype wire

// ### tb/mtrl_type_lookup_sva.sv
`timescale 1ns/1ns
`default_nettype none
// port-level checks of the memory type lookup
module mtrl_type_lookup_sva #(
   parameter int PA_W = 52
) (
   input wire logic            CORE_CLK_IN,
   input wire logic            RST_N_IN,
   input wire logic            CLK_EN_IN,
   input wire logic            MSR_WR_IN,
   input wire logic            MSR_RD_IN,
   input wire logic [4:0]      MSR_SEL_IN,
   input wire logic [63:0]     MSR_WDATA_IN,
   input wire logic            MSR_RVALID_OUT,
   input wire logic            MSR_ERR_OUT,
   input wire logic            LOOK_REQ_IN,
   input wire logic [PA_W-1:0] LOOK_ADDR_IN,
   input wire logic            LOOK_VALID_OUT,
   input wire logic [2:0]      LOOK_TYPE_OUT,
   input wire logic            LOOK_READ_TO_MEMORY_BIT_OUT,
   input wire logic            LOOK_WRITE_TO_MEMORY_BIT_OUT,
   input wire logic            LOOK_FIXED_OUT
);
   logic [11:0] def_r;  // shadow of the default control bits
   logic        take;   // lookup taken at this edge
   logic        low;    // address inside the lowest megabyte
   assign take = LOOK_REQ_IN && CLK_EN_IN;
   assign low  = (LOOK_ADDR_IN >> 20) == '0;
   // shadow follows writes, since enables live only inside the block
   always_ff @(posedge CORE_CLK_IN or negedge RST_N_IN)
   begin
      if (!RST_N_IN)
         def_r <= 12'h000;
      else if (CLK_EN_IN && MSR_WR_IN && MSR_SEL_IN == mtrl_pkg::SEL_DEF_TYPE)
         def_r <= MSR_WDATA_IN[11:0];
   end
   default clocking cb @(posedge CORE_CLK_IN); endclocking
   default disable iff (!RST_N_IN);
   AST_LOOK_ANSWER: assert property (take |=> LOOK_VALID_OUT)
      else $error("lookup answer missing");
   AST_LOOK_QUIET: assert property (CLK_EN_IN && !LOOK_REQ_IN
      |=> !LOOK_VALID_OUT && $stable(LOOK_TYPE_OUT))
      else $error("lookup answer without request");
   AST_READ_ANSWER: assert property (CLK_EN_IN && MSR_RD_IN && MSR_SEL_IN <= 5'h1b
      |=> MSR_RVALID_OUT && !MSR_ERR_OUT)
      else $error("register read not answered");
   AST_UNMAPPED: assert property (CLK_EN_IN && (MSR_RD_IN || MSR_WR_IN) && MSR_SEL_IN > 5'h1b
      |=> MSR_ERR_OUT && !MSR_RVALID_OUT)
      else $error("unmapped selector not refused");
   AST_RVALID_CAUSE: assert property (MSR_RVALID_OUT && $past(CLK_EN_IN)
      |-> $past(MSR_RD_IN))
      else $error("read valid without read");
   AST_GLOBAL_OFF: assert property (take && !def_r[11] |=> LOOK_TYPE_OUT == 3'h0
      && !LOOK_FIXED_OUT)
      else $error("typing disabled but type not uncacheable");
   AST_FIXED_LOW_ONLY: assert property (take && !low |=> !LOOK_FIXED_OUT && !LOOK_READ_TO_MEMORY_BIT_OUT
      && !LOOK_WRITE_TO_MEMORY_BIT_OUT)
      else $error("fixed range used above one megabyte");
   AST_FIXED_DISABLED: assert property (take && !def_r[10] |=> !LOOK_FIXED_OUT
      && !LOOK_READ_TO_MEMORY_BIT_OUT && !LOOK_WRITE_TO_MEMORY_BIT_OUT)
      else $error("fixed range used while disabled");
   AST_FIXED_WINS: assert property (take && low && def_r[11] && def_r[10] |=> LOOK_FIXED_OUT)
      else $error("fixed range not preferred");
   AST_FROZEN: assert property (!CLK_EN_IN |=> $stable(LOOK_VALID_OUT)
      && $stable(MSR_RVALID_OUT) && $stable(MSR_ERR_OUT))
      else $error("outputs moved while clock enable low");
endmodule : mtrl_type_lookup_sva
`default_nettype wire

// ### tb/testbench.sv
`timescale 1ns/1ns
`default_nettype none
`define CHK(got, exp) begin tests_run++; if ((got) !== (exp)) begin num_errors++; \
   $display("wrong value at %0t: got %h expected %h", $time, (got), (exp)); end end
module testbench;
   localparam int PA_W  = 36;    // narrower implemented address space
   localparam int LIMIT = 10000; // cycle ceiling for a hang
   logic            core_clk, rst_n, clk_en, msr_wr, msr_rd;  // driven inputs
   logic [4:0]      msr_sel;                                  // selector
   logic [63:0]     msr_wdata, def_m;                         // write data, model
   logic [63:0]     fix_m [11];                               // fixed register model
   logic [63:0]     base_m [8], mask_m [8];                   // variable pair model
   wire logic [63:0] msr_rdata;
   wire logic       msr_rvalid, msr_err, look_req, look_valid, look_rd, look_wr, look_fixed;
   wire logic [2:0] look_type;
   wire logic [PA_W-1:0] look_addr;
   int              num_errors, tests_run, seed, cycles;
   logic [2:0]      codes [5] = '{3'h0, 3'h1, 3'h4, 3'h5, 3'h6};  // standard types
   mtrl_access_model #(.PA_W(PA_W)) i_mtrl_access_model (.req_out(look_req),
      .addr_out(look_addr));
   mtrl_type_lookup #(.PA_W(PA_W)) i_mtrl_type_lookup (.CORE_CLK_IN(core_clk),
      .RST_N_IN(rst_n), .CLK_EN_IN(clk_en), .MSR_WR_IN(msr_wr), .MSR_RD_IN(msr_rd),
      .MSR_SEL_IN(msr_sel), .MSR_WDATA_IN(msr_wdata), .MSR_RDATA_OUT(msr_rdata),
      .MSR_RVALID_OUT(msr_rvalid), .MSR_ERR_OUT(msr_err), .LOOK_REQ_IN(look_req),
      .LOOK_ADDR_IN(look_addr), .LOOK_VALID_OUT(look_valid), .LOOK_TYPE_OUT(look_type),
      .LOOK_READ_TO_MEMORY_BIT_OUT(look_rd), .LOOK_WRITE_TO_MEMORY_BIT_OUT(look_wr), .LOOK_FIXED_OUT(look_fixed));
   always #25 core_clk = ~core_clk;
   // reference answer {fixed, read bit, write bit, type}
   function automatic logic [5:0] ref_look(input logic [PA_W-1:0] a);
      logic [7:0] pg, f;
      logic [2:0] t, first, res;
      int         idx, hits;
      logic       any_unc, mixed, through_back, low;
      pg = a[19:12];
      if (pg < 8'h80) begin f = fix_m[0][pg[6:4]*8 +: 8]; end
      else if (pg < 8'hc0) begin idx = (pg - 8'h80) >> 2;
         f = fix_m[1+idx/8][(idx%8)*8 +: 8]; end
      else begin idx = pg - 8'hc0; f = fix_m[3+idx/8][(idx%8)*8 +: 8]; end
      low = (a >> 20) == 0;
      hits = 0; any_unc = 0; mixed = 0; through_back = 1; first = 3'h0;
      for (int n = 0; n < 8; n++)
         if (mask_m[n][11] && ((mask_m[n][PA_W-1:12] & base_m[n][PA_W-1:12])
             == (mask_m[n][PA_W-1:12] & a[PA_W-1:12])))
         begin
            t = base_m[n][2:0];
            if (hits == 0) first = t;
            else if (t != first) mixed = 1;
            any_unc |= t == 3'h0;
            through_back &= t == 3'h4 || t == 3'h6;
            hits++;
         end
      // overlap resolution, uncovered space takes the default
      res = hits == 0 ? def_m[2:0] : any_unc ? 3'h0 : !mixed ? first
         : through_back ? 3'h4 : 3'h0;
      if (!def_m[11]) res = 3'h0;
      else if (low && def_m[10]) res = f[2:0];
      return {def_m[11] && def_m[10] && low, (low && def_m[10]) ? f[4:3] : 2'b00, res};
   endfunction : ref_look
   // one register access; strobes stay up until the next call or idle
   task automatic msr(input logic wr, input logic [4:0] sel, input logic [63:0] d, exp);
      msr_wr = wr; msr_rd = !wr; msr_sel = sel; msr_wdata = d;
      @(posedge core_clk);
      #1;
      `CHK({msr_err, msr_rvalid}, {sel > 5'h1b, !wr && sel <= 5'h1b})
      if (!wr && sel <= 5'h1b) `CHK(msr_rdata, exp)
   endtask : msr
   // read back every selector, the four unmapped ones included
   task automatic readback();
      for (int s = 0; s < 32; s++)
         msr(0, 5'(s), 64'h0, s < 11 ? fix_m[s] : s == 27 ? def_m : s > 27 ? 64'h0
            : s % 2 ? base_m[(s-11)/2] : mask_m[(s-12)/2]);
      msr_rd = 0;
   endtask : readback
   // random lookups, some with the clock enable low
   task automatic look_run(input int count);
      logic [PA_W-1:0] a;
      int c;
      logic en, rq, v;
      v = 1'b0;
      repeat (count)
      begin
         c = {$random(seed)} % 3;
         a = PA_W'({$random(seed), $random(seed)});
         if (c == 0) a = a & 'hf_ffff;
         else if (c == 1) a = a & 'h3ff_ffff;
         en = ({$random(seed)} % 8) != 0;
         rq = ({$random(seed)} % 4) != 0;
         clk_en = en;
         i_mtrl_access_model.drive(rq, a);
         @(posedge core_clk);
         #1;
         if (en) v = rq;  // a low enable freezes the answer pulse
         `CHK(look_valid, v)
         if (rq && en) `CHK({look_fixed, look_rd, look_wr, look_type}, ref_look(a))
      end
      clk_en = 1;
      i_mtrl_access_model.drive(0, '0);
   endtask : look_run
   // verdict and end of run
   task automatic conclude();
      if (num_errors == 0 && tests_run > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : conclude
   // hang guard
   always @(posedge core_clk)
   begin
      cycles++;
      if (cycles == LIMIT)
      begin
         num_errors++;
         conclude();
      end
   end
   // main sequence
   initial
   begin
      logic [63:0] size, b;
      core_clk = 0; rst_n = 0; clk_en = 1; msr_wr = 0; msr_rd = 0; msr_sel = 5'h00;
      msr_wdata = 64'h0; def_m = 64'h0; num_errors = 0; tests_run = 0; cycles = 0;
      seed = 32'h25e2cf42;
      for (int i = 0; i < 11; i++) fix_m[i] = 64'h0;
      for (int n = 0; n < 8; n++) begin base_m[n] = 64'h0; mask_m[n] = 64'h0; end
      repeat (12) @(posedge core_clk);
      #1;
      rst_n = 1;
      readback();
      msr(1, 5'h1d, 64'hffff_ffff_ffff_ffff, 64'h0);
      for (int i = 0; i < 11; i++)
      begin
         fix_m[i] = {$random(seed), $random(seed)};
         msr(1, 5'(i), fix_m[i], 64'h0);
      end
      for (int r = 0; r < 3; r++)
      begin
         // aligned power-of-two ranges, many of them overlapping
         for (int n = 0; n < 8; n++)
         begin
            size = 64'h1 << (12 + {$random(seed)} % 13);
            b = {$random(seed)} & 64'h3ff_ffff & ~(size - 1);
            if ({$random(seed)} % 3 == 0) b = b & 64'hf_ffff;
            base_m[n] = b | codes[{$random(seed)} % 5];
            mask_m[n] = ((((64'h1 << PA_W) - size) >> 12) << 12)
               | (64'(({$random(seed)} % 4) != 0) << 11);
            msr(1, 5'(11 + 2 * n), base_m[n], 64'h0);
            msr(1, 5'(12 + 2 * n), mask_m[n], 64'h0);
         end
         // all four enable combinations
         for (int m = 0; m < 4; m++)
         begin
            def_m = {52'h0, m[1], m[0], 7'h0, codes[{$random(seed)} % 5]};
            msr(1, 5'h1b, def_m, 64'h0);
            readback();
            msr_wr = 0;
            look_run(150);
         end
      end
      conclude();
   end
endmodule : testbench
bind mtrl_type_lookup mtrl_type_lookup_sva #(.PA_W(PA_W)) i_mtrl_type_lookup_sva (
   .CORE_CLK_IN(CORE_CLK_IN), .RST_N_IN(RST_N_IN), .CLK_EN_IN(CLK_EN_IN),
   .MSR_WR_IN(MSR_WR_IN), .MSR_RD_IN(MSR_RD_IN), .MSR_SEL_IN(MSR_SEL_IN),
   .MSR_WDATA_IN(MSR_WDATA_IN), .MSR_RVALID_OUT(MSR_RVALID_OUT), .MSR_ERR_OUT(MSR_ERR_OUT),
   .LOOK_REQ_IN(LOOK_REQ_IN), .LOOK_ADDR_IN(LOOK_ADDR_IN), .LOOK_VALID_OUT(LOOK_VALID_OUT),
   .LOOK_TYPE_OUT(LOOK_TYPE_OUT), .LOOK_READ_TO_MEMORY_BIT_OUT(LOOK_READ_TO_MEMORY_BIT_OUT),
   .LOOK_WRITE_TO_MEMORY_BIT_OUT(LOOK_WRITE_TO_MEMORY_BIT_OUT), .LOOK_FIXED_OUT(LOOK_FIXED_OUT));
`default_nettype wire

// ### verilog/mtrl_fixed_lookup.sv
`timescale 1ns/1ns
`default_nettype none
// picks the fixed-range type field covering a sub-megabyte address
module mtrl_fixed_lookup (
   input  wire logic [19:12]    page_in,        // address bits 19:12
   input  wire logic [703:0]    fix_regs_in,    // eleven packed fixed registers
   output logic      [7:0]      field_out       // selected byte-wide field
);
   logic [6:0] idx;  // field number 0..87
   // decode region then sub-range
   always_comb
   begin
      if (page_in < mtrl_pkg::PG_16K_START)
         idx = {4'h0, page_in[18:16]};
      else if (page_in < mtrl_pkg::PG_4K_START)
         idx = 7'd8 + {3'h0, page_in[17:14]};
      else
         idx = 7'd24 + {1'b0, page_in[17:12]};
   end
   // low byte is the lowest sub-range, fields packed upward
   assign field_out = fix_regs_in[idx*8 +: 8];
endmodule : mtrl_fixed_lookup
`default_nettype wire

// ### verilog/mtrl_type_lookup.sv
`timescale 1ns/1ns
`default_nettype none
// How it works
// - fixed ranges only below one megabyte
// - uncovered addresses take default type
// - 64-bit registers via model register port
// - byte fields ordered low to high address
// - 88 fixed sub-ranges, one field each
// - 0-7ffff: eight 64k ranges, one register
// - 80000-bffff: sixteen 16k ranges, two registers
// - c0000-fffff: sixty-four 4k ranges, eight registers
// - fixed fields keep read/write memory bits
// - variable and default use standard codes
// - eight variable base/mask pairs
// - base: type 7:0, address 51:12
// - mask: address mask 51:12
// - mask bit 11 validates the pair
// - masked base equals masked address
// - variable fields read/write
// - compare only implemented address bits
// - default type in bits 7:0, read/write
// - bit 10 enables fixed ranges
// - bit 11 global enable, else uncacheable
// - type in bits 2:0, extension bits 4:3
// - type codes 0,1,4,5,6
// - fixed range beats variable range
// - variable overlap: same, uncacheable, write-through
module mtrl_type_lookup #(
   parameter int PA_W    = 52,  // implemented physical address width
   parameter int NUM_VAR = mtrl_pkg::NUM_VAR
) (
   input  wire logic             CORE_CLK_IN,     // 20 MHz core clock
   input  wire logic             RST_N_IN,        // async reset, active low
   input  wire logic             CLK_EN_IN,       // freezes all state when low
   // model register port, driven by the read/write instructions
   input  wire logic             MSR_WR_IN,       // write strobe
   input  wire logic             MSR_RD_IN,       // read strobe
   input  wire logic [4:0]       MSR_SEL_IN,      // register selector
   input  wire logic [63:0]      MSR_WDATA_IN,    // write data
   output logic      [63:0]      MSR_RDATA_OUT,   // read data
   output logic                  MSR_RVALID_OUT,  // read data valid pulse
   output logic                  MSR_ERR_OUT,     // unmapped selector pulse
   // lookup request from the memory access path
   input  wire logic             LOOK_REQ_IN,     // request strobe
   input  wire logic [PA_W-1:0]  LOOK_ADDR_IN,    // physical address
   output logic                  LOOK_VALID_OUT,  // answer valid pulse
   output logic      [2:0]       LOOK_TYPE_OUT,   // resolved memory type
   output logic                  LOOK_READ_TO_MEMORY_BIT_OUT,  // read_to_memory_bit of answer
   output logic                  LOOK_WRITE_TO_MEMORY_BIT_OUT,  // write_to_memory_bit of answer
   output logic                  LOOK_FIXED_OUT   // answer came from a fixed range
);
   // storage
   // all registers are flip-flops
   // only implemented address bits kept;
   // higher bits read back as zero
   // reserved base/mask bits not stored:
   // saves area, junk writes not echoed
   logic [63:0]      fix_r [mtrl_pkg::NUM_FIX];  // fixed-range registers
   logic [PA_W-1:12] base_addr_r [NUM_VAR];      // range_base_field
   logic [7:0]       base_type_r [NUM_VAR];      // variable type
   logic [PA_W-1:12] mask_addr_r [NUM_VAR];      // range_mask_field
   logic [NUM_VAR-1:0] valid_r;                  // pair-valid flags
   logic [7:0]       def_type_r;                 // default type field
   logic             fix_en_r;                   // fixed_range_enable
   logic             glob_en_r;                  // global enable
   logic [703:0]     fix_flat;                   // packed fixed registers
   logic [NUM_VAR-1:0] hit;                      // per pair hit
   logic [7:0]       fix_field;                  // selected fixed field
   logic             in_low_mb;                  // address below one megabyte
   logic [2:0]       type_nxt;                   // resolved type
   logic             rd_nxt;                     // resolved read bit
   logic             wr_nxt;                     // resolved write bit
   logic             fixed_nxt;                  // resolved via fixed range
   logic [63:0]      rdata_nxt;                  // read mux
   logic             sel_ok;                     // selector mapped
   logic             var_sel;                    // selector in variable block
   logic [4:0]       var_off;                    // offset into variable block
   logic [2:0]       var_idx;                    // pair index
   logic [NUM_VAR-1:0] hit_uc, hit_wt, hit_wb, hit_other; // type hit classes
   logic [2:0]       first_type;                 // type of lowest hit pair
   logic             all_same;                   // all hits share one type

   // selector map: eleven fixed words,
   // then base/mask pairs, default last
   // pair index is the offset halved;
   // low bit: base (even) or mask (odd)
   // above default word: unmapped
   // selector decode for the variable block
   assign var_sel = (MSR_SEL_IN >= mtrl_pkg::SEL_VAR_BASE0)
                    && (MSR_SEL_IN < mtrl_pkg::SEL_DEF_TYPE);
   assign var_off = MSR_SEL_IN - mtrl_pkg::SEL_VAR_BASE0;
   assign var_idx = var_off[3:1];
   assign sel_ok  = (MSR_SEL_IN <= mtrl_pkg::SEL_DEF_TYPE);

   // fixed registers, written whole
   // no field check: reserved codes
   // stored, software owns legality
   // extension bits ride in each field
   // same-cycle write and lookup: the
   // lookup still sees the old value
   genvar gf;
   generate
      for (gf = 0; gf < mtrl_pkg::NUM_FIX; gf++)
      begin : g_fix
         always_ff @(posedge CORE_CLK_IN or negedge RST_N_IN)
         begin
            if (!RST_N_IN)
               fix_r[gf] <= mtrl_pkg::RST_VALUE;
            else if (CLK_EN_IN && MSR_WR_IN && MSR_SEL_IN == 5'(gf))
               fix_r[gf] <= MSR_WDATA_IN;
         end
         assign fix_flat[gf*64 +: 64] = fix_r[gf];
      end
   endgenerate

   // variable pairs and their comparators
   // one generate pass per pair
   // comparators are combinational,
   // so a request resolves in-cycle
   // wide and-compare is the long path;
   // a narrower width shortens it
   genvar gv;
   generate
      for (gv = 0; gv < NUM_VAR; gv++)
      begin : g_var
         // base and mask writes
         // odd selector: base word
         // even selector: mask and valid
         // clear valid first, else a
         // half-set pair may match
         always_ff @(posedge CORE_CLK_IN or negedge RST_N_IN)
         begin
            if (!RST_N_IN)
            begin
               base_addr_r[gv] <= '0;
               base_type_r[gv] <= 8'h00;
               mask_addr_r[gv] <= '0;
               valid_r[gv]     <= 1'b0;
            end
            else if (CLK_EN_IN && MSR_WR_IN && var_sel && var_idx == 3'(gv))
            begin
               if (!var_off[0])
               begin
                  base_type_r[gv] <= MSR_WDATA_IN[7:0];
                  base_addr_r[gv] <= MSR_WDATA_IN[PA_W-1:12];
               end
               else
               begin
                  mask_addr_r[gv] <= MSR_WDATA_IN[PA_W-1:12];
                  valid_r[gv]     <= MSR_WDATA_IN[mtrl_pkg::VALID_BIT];
               end
            end
         end
         mtrl_var_match #(.PA_W(PA_W)) u_match (
            .addr_in  (LOOK_ADDR_IN[PA_W-1:12]),
            .base_in  (base_addr_r[gv]),
            .mask_in  (mask_addr_r[gv]),
            .valid_in (valid_r[gv]),
            .hit_out  (hit[gv])
         );
         // classify hits by standard type bits only
         // bits 7:3 kept for read-back only,
         // never reach the resolver
         assign hit_uc[gv]    = hit[gv] && base_type_r[gv][2:0] == mtrl_pkg::MT_UNCACHEABLE;
         assign hit_wt[gv]    = hit[gv] && base_type_r[gv][2:0] == mtrl_pkg::MT_WRITE_THROUGH;
         assign hit_wb[gv]    = hit[gv] && base_type_r[gv][2:0] == mtrl_pkg::MT_WRITE_BACK;
         assign hit_other[gv] = hit[gv] && base_type_r[gv][2:0] != first_type;
      end
   endgenerate

   // default-type control register
   // type low byte, enables above
   // other bits not stored, read zero
   // reset clears: typing off, every
   // lookup uncacheable until enabled
   // new enables apply next cycle
   always_ff @(posedge CORE_CLK_IN or negedge RST_N_IN)
   begin
      if (!RST_N_IN)
      begin
         def_type_r <= 8'h00;
         fix_en_r   <= 1'b0;
         glob_en_r  <= 1'b0;
      end
      else if (CLK_EN_IN && MSR_WR_IN && MSR_SEL_IN == mtrl_pkg::SEL_DEF_TYPE)
      begin
         def_type_r <= MSR_WDATA_IN[7:0];
         fix_en_r   <= MSR_WDATA_IN[mtrl_pkg::FE_BIT];
         glob_en_r  <= MSR_WDATA_IN[mtrl_pkg::EN_BIT];
      end
   end

   // fixed field selection
   // field picked from low address bits
   // for any address; in_low_mb gates
   // it, so the shared mux costs nothing
   // extra outside the lowest megabyte
   mtrl_fixed_lookup u_fixed (
      .page_in     (LOOK_ADDR_IN[19:12]),
      .fix_regs_in (fix_flat),
      .field_out   (fix_field)
   );
   // fixed ranges apply only inside the lowest megabyte
   assign in_low_mb = (LOOK_ADDR_IN[PA_W-1:20] == '0);

   // lowest-numbered hit supplies the reference type
   // any hit could be the reference:
   // a mismatch means a mix either way
   // downward loop: lowest index last
   // no hit: default taken downstream
   always_comb
   begin
      first_type = mtrl_pkg::MT_UNCACHEABLE;
      for (int i = NUM_VAR - 1; i >= 0; i--)
         if (hit[i])
            first_type = base_type_r[i][2:0];
   end
   assign all_same = (hit_other == '0);

   // resolution priority
   // order: global off, fixed range,
   // variable hits, default type
   // extension bits only from fixed
   // fields, need the fixed enable,
   // ignore the global enable
   // open mixes fall to uncacheable,
   // the safest answer
   always_comb
   begin
      type_nxt  = def_type_r[2:0];
      rd_nxt    = 1'b0;
      wr_nxt    = 1'b0;
      fixed_nxt = 1'b0;
      if (in_low_mb && fix_en_r)
      begin
         // extension bits pass even with typing off
         rd_nxt = fix_field[mtrl_pkg::EXT_RD_BIT];
         wr_nxt = fix_field[mtrl_pkg::EXT_WR_BIT];
      end
      if (!glob_en_r)
         type_nxt = mtrl_pkg::MT_UNCACHEABLE;
      else if (in_low_mb && fix_en_r)
      begin
         type_nxt  = fix_field[2:0];
         fixed_nxt = 1'b1;
      end
      else if (hit != '0)
      begin
         // overlap resolution; undefined mixes fall back to uncacheable
         if (hit_uc != '0)
            type_nxt = mtrl_pkg::MT_UNCACHEABLE;
         else if (all_same)
            type_nxt = first_type;
         else if ((hit_wt | hit_wb) == hit)
            type_nxt = mtrl_pkg::MT_WRITE_THROUGH;
         else
            type_nxt = mtrl_pkg::MT_UNCACHEABLE;
      end
   end

   // registered answer, one cycle after request
   // valid follows request when enabled
   // type and bits load only on request,
   // holding the last answer when idle
   // low clock enable freezes valid too;
   // consumers qualify with the enable
   // a request every cycle is accepted
   always_ff @(posedge CORE_CLK_IN or negedge RST_N_IN)
   begin
      if (!RST_N_IN)
      begin
         LOOK_VALID_OUT <= 1'b0;
         LOOK_TYPE_OUT  <= 3'h0;
         LOOK_READ_TO_MEMORY_BIT_OUT <= 1'b0;
         LOOK_WRITE_TO_MEMORY_BIT_OUT <= 1'b0;
         LOOK_FIXED_OUT <= 1'b0;
      end
      else if (CLK_EN_IN)
      begin
         LOOK_VALID_OUT <= LOOK_REQ_IN;
         if (LOOK_REQ_IN)
         begin
            LOOK_TYPE_OUT  <= type_nxt;
            LOOK_READ_TO_MEMORY_BIT_OUT <= rd_nxt;
            LOOK_WRITE_TO_MEMORY_BIT_OUT <= wr_nxt;
            LOOK_FIXED_OUT <= fixed_nxt;
         end
      end
   end

   // read mux; unused high bits read as zero
   // fixed words: all 64 bits
   // base: type and address
   // mask: valid flag and address
   // default: type byte and enables
   // unmapped: mux stays zero
   always_comb
   begin
      rdata_nxt = 64'h0;
      if (MSR_SEL_IN < mtrl_pkg::SEL_VAR_BASE0)
         rdata_nxt = fix_r[MSR_SEL_IN[3:0]];
      else if (var_sel && !var_off[0])
      begin
         rdata_nxt[7:0]       = base_type_r[var_idx];
         rdata_nxt[PA_W-1:12] = base_addr_r[var_idx];
      end
      else if (var_sel)
      begin
         rdata_nxt[mtrl_pkg::VALID_BIT] = valid_r[var_idx];
         rdata_nxt[PA_W-1:12]           = mask_addr_r[var_idx];
      end
      else if (MSR_SEL_IN == mtrl_pkg::SEL_DEF_TYPE)
      begin
         rdata_nxt[7:0]                = def_type_r;
         rdata_nxt[mtrl_pkg::FE_BIT]   = fix_en_r;
         rdata_nxt[mtrl_pkg::EN_BIT]   = glob_en_r;
      end
   end

   // read answer one cycle later; unmapped selector flags an error
   // data loads on mapped reads only,
   // held after the valid pulse ends
   // same-cycle read and write of one
   // word returns the old value
   // error pulse covers both strobes
   always_ff @(posedge CORE_CLK_IN or negedge RST_N_IN)
   begin
      if (!RST_N_IN)
      begin
         MSR_RDATA_OUT  <= 64'h0;
         MSR_RVALID_OUT <= 1'b0;
         MSR_ERR_OUT    <= 1'b0;
      end
      else if (CLK_EN_IN)
      begin
         MSR_RVALID_OUT <= MSR_RD_IN && sel_ok;
         MSR_ERR_OUT    <= (MSR_RD_IN || MSR_WR_IN) && !sel_ok;
         if (MSR_RD_IN && sel_ok)
            MSR_RDATA_OUT <= rdata_nxt;
      end
   end
endmodule : mtrl_type_lookup
`default_nettype wire

// ### verilog/mtrl_var_match.sv
`timescale 1ns/1ns
`default_nettype none
// one variable base/mask comparator
module mtrl_var_match #(
   parameter int PA_W = 52
) (
   input  wire logic [PA_W-1:12] addr_in,   // target page number
   input  wire logic [PA_W-1:12] base_in,   // stored base field
   input  wire logic [PA_W-1:12] mask_in,   // stored mask field
   input  wire logic             valid_in,  // pair-valid flag
   output logic                  hit_out    // pair hits
);
   // only implemented bits compared; invalid pair never hits
   assign hit_out = valid_in && ((mask_in & base_in) == (mask_in & addr_in));
endmodule : mtrl_var_match
`default_nettype wire
